// >>> logic/cputmr_top.sv
// Timer: 32-bit down counter with control/status flags and debug halt
//
// Summary of operation
// - Zero reached sets flag bit 15
// - Writing one clears flag; zero ignored
// - Zero with enable bit 14 raises irq
// - Enable clear: never any irq
// - Emulation bits act only during debug halt
// - Free-run keeps counting, soft bit ignored
// - Hard mode stops after next decrement
// - Soft mode stops once count reaches zero
// - Decrement every divisor+1 clocks, reload at zero
// - Reload strobe loads count and prescaler
// - Stop bit resets zero; zero runs
`timescale 1ns/1ps
module cputmr_top (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire cputmr_pkg::cputmr_bus_t BUS_I,
    output logic [cputmr_pkg::DATA_W-1:0] BUS_RDATA_O,
    input wire logic DEBUG_HALT_I,
    output logic ZERO_IRQ_O
);
    import cputmr_pkg::*;

    cputmr_state_t st_q;
    cputmr_state_t st_d;
    logic wr_tcr;
    logic reload_wr;
    logic cnt_wr;
    logic run;
    logic tick;
    logic zero_evt;
    logic [31:0] next_cnt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        st_d.irq = 1'b0;
        wr_tcr = BUS_I.wr && (BUS_I.addr == OFF_TCR);
        reload_wr = wr_tcr && BUS_I.wdata[BIT_RELOAD];
        cnt_wr = BUS_I.wr && ((BUS_I.addr == OFF_CNT_LO) ||
                 (BUS_I.addr == OFF_CNT_HI));
        run = !st_q.halt_request_bit && (st_q.emu == EMU_RUN);
        tick = run && (st_q.prescale_counter == 32'h0000_0000);
        next_cnt = (st_q.down_count == 32'h0000_0000) ?
                   st_q.reload_period : st_q.down_count - 32'h0000_0001;
        zero_evt = tick && (next_cnt == 32'h0000_0000);

        if (run) begin
            if (tick) begin
                st_d.prescale_counter = st_q.prescale_divisor;
                st_d.down_count = next_cnt;
            end else begin
                st_d.prescale_counter = st_q.prescale_counter - 32'h0000_0001;
            end
        end

        // Software writes win over the running count
        if (BUS_I.wr) begin
            case (BUS_I.addr)
                OFF_CNT_LO: st_d.down_count[15:0] = BUS_I.wdata;
                OFF_CNT_HI: st_d.down_count[31:16] = BUS_I.wdata;
                OFF_PRD_LO: st_d.reload_period[15:0] = BUS_I.wdata;
                OFF_PRD_HI: st_d.reload_period[31:16] = BUS_I.wdata;
                OFF_DIV_LO: st_d.prescale_divisor[15:0] = BUS_I.wdata;
                OFF_DIV_HI: st_d.prescale_divisor[31:16] = BUS_I.wdata;
                OFF_TCR: begin
                    st_d.zero_irq_enable = BUS_I.wdata[BIT_IRQEN];
                    st_d.free_run = BUS_I.wdata[BIT_FREE];
                    st_d.soft_halt = BUS_I.wdata[BIT_SOFT];
                    st_d.halt_request_bit = BUS_I.wdata[BIT_HALTREQ];
                end
                default: st_d.rdata = st_q.rdata;
            endcase
        end

        if (reload_wr) begin
            st_d.down_count = st_q.reload_period;
            st_d.prescale_counter = st_q.prescale_divisor;
        end

        if (wr_tcr && BUS_I.wdata[BIT_ZFLAG]) begin
            st_d.zero_reached_flag = 1'b0;
        end
        // set after clear so a same-cycle event is kept
        if (zero_evt) begin
            st_d.zero_reached_flag = 1'b1;
        end
        st_d.irq = zero_evt && st_q.zero_irq_enable;

        // emulation bits looked at only under debug halt
        case (st_q.emu)
            EMU_RUN: begin
                // hard stop; soft stop waits for zero
                if (DEBUG_HALT_I && !st_q.free_run && tick &&
                    (!st_q.soft_halt || zero_evt)) begin
                    st_d.emu = EMU_FROZEN;
                end
            end
            EMU_FROZEN: begin
                if (!DEBUG_HALT_I || st_q.free_run) begin
                    st_d.emu = EMU_RUN;
                end
            end
            default: st_d.emu = EMU_RUN;
        endcase

        // Reserved bits and the strobe read as zero
        if (BUS_I.rd) begin
            case (BUS_I.addr)
                OFF_CNT_LO: st_d.rdata = st_q.down_count[15:0];
                OFF_CNT_HI: st_d.rdata = st_q.down_count[31:16];
                OFF_PRD_LO: st_d.rdata = st_q.reload_period[15:0];
                OFF_PRD_HI: st_d.rdata = st_q.reload_period[31:16];
                OFF_DIV_LO: st_d.rdata = st_q.prescale_divisor[15:0];
                OFF_DIV_HI: st_d.rdata = st_q.prescale_divisor[31:16];
                OFF_TCR: st_d.rdata = {st_q.zero_reached_flag,
                    st_q.zero_irq_enable, 2'h0, st_q.free_run,
                    st_q.soft_halt, 4'h0, 1'b0, st_q.halt_request_bit, 4'h0};
                default: st_d.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            st_q <= '{down_count: RST_COUNT, reload_period: RST_PERIOD,
                      prescale_divisor: RST_DIVISOR,
                      prescale_counter: RST_DIVISOR,
                      zero_reached_flag: 1'b0, zero_irq_enable: 1'b0,
                      free_run: 1'b0, soft_halt: 1'b0,
                      halt_request_bit: 1'b0, emu: EMU_RUN, irq: 1'b0,
                      rdata: 16'h0000};
        end else begin
            st_q <= st_d;
        end
    end

    assign BUS_RDATA_O = st_q.rdata;
    assign ZERO_IRQ_O = st_q.irq;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    property p_flag_set;
        zero_evt |=> st_q.zero_reached_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set on zero");

    property p_flag_clear;
        wr_tcr && BUS_I.wdata[BIT_ZFLAG] && !zero_evt
            |=> !st_q.zero_reached_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared by write of one");

    property p_flag_hold;
        !zero_evt && !(wr_tcr && BUS_I.wdata[BIT_ZFLAG])
            |=> $stable(st_q.zero_reached_flag);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag changed without cause");

    property p_irq_on;
        zero_evt && st_q.zero_irq_enable |=> ZERO_IRQ_O ##1 !ZERO_IRQ_O
            or ZERO_IRQ_O;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("irq missing on enabled zero");

    property p_irq_cause;
        ZERO_IRQ_O |-> $past(zero_evt) && $past(st_q.zero_irq_enable);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq without enabled zero");

    property p_frozen_debug;
        st_q.emu == EMU_FROZEN |-> $past(DEBUG_HALT_I);
    endproperty
    a_frozen_debug: assert property (p_frozen_debug)
        else $error("frozen without debug halt");

    property p_free;
        DEBUG_HALT_I && st_q.free_run |=> st_q.emu == EMU_RUN;
    endproperty
    a_free: assert property (p_free)
        else $error("free run stopped");

    property p_hard;
        DEBUG_HALT_I && !st_q.free_run && !st_q.soft_halt && tick
            |=> st_q.emu == EMU_FROZEN ##1 $stable(st_q.down_count);
    endproperty
    a_hard: assert property (p_hard)
        else $error("hard stop missed");

    property p_soft;
        DEBUG_HALT_I && !st_q.free_run && st_q.soft_halt && tick &&
            !zero_evt && st_q.emu == EMU_RUN |=> st_q.emu == EMU_RUN;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft stop before zero");

    property p_wrap;
        tick && !cnt_wr && !reload_wr && st_q.down_count == 32'h0000_0000
            |=> st_q.down_count == $past(st_q.reload_period);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("no reload from period");

    property p_reload;
        reload_wr |=> st_q.down_count == $past(st_q.reload_period) &&
            st_q.prescale_counter == $past(st_q.prescale_divisor);
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload strobe ignored");

    property p_start;
        wr_tcr && !BUS_I.wdata[BIT_HALTREQ] |=> !st_q.halt_request_bit;
    endproperty
    a_start: assert property (p_start)
        else $error("stop bit not cleared");

    property p_poll;
        zero_evt && !st_q.zero_irq_enable
            |=> st_q.zero_reached_flag && !ZERO_IRQ_O;
    endproperty
    a_poll: assert property (p_poll)
        else $error("polled flag wrong");

    c_irq: cover property (ZERO_IRQ_O);
    c_frozen: cover property (st_q.emu == EMU_FROZEN);
    c_set_clear: cover property (zero_evt && wr_tcr &&
        BUS_I.wdata[BIT_ZFLAG]);
    c_reload: cover property (reload_wr);
endmodule

// >>> logic/cputmr_pkg.sv
// Package: register map, field positions, reset values and types of the timer
package cputmr_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    // Word offsets inside the timer block
    localparam logic [2:0] OFF_CNT_LO = 3'h0;
    localparam logic [2:0] OFF_CNT_HI = 3'h1;
    localparam logic [2:0] OFF_PRD_LO = 3'h2;
    localparam logic [2:0] OFF_PRD_HI = 3'h3;
    localparam logic [2:0] OFF_TCR = 3'h4;
    localparam logic [2:0] OFF_DIV_LO = 3'h6;
    localparam logic [2:0] OFF_DIV_HI = 3'h7;

    // Control register field positions
    localparam int BIT_ZFLAG = 15;
    localparam int BIT_IRQEN = 14;
    localparam int BIT_FREE = 11;
    localparam int BIT_SOFT = 10;
    localparam int BIT_RELOAD = 5;
    localparam int BIT_HALTREQ = 4;

    // Reset values
    localparam logic [31:0] RST_PERIOD = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_COUNT = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_DIVISOR = 32'h0000_0000;

    // Debug-halt behaviour of the counter, one-hot
    typedef enum logic [1:0] {
        EMU_RUN = 2'b01,
        EMU_FROZEN = 2'b10
    } cputmr_emu_t;

    // One memory-bus access, same clock as the timer
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cputmr_bus_t;

    // Whole state of the timer
    typedef struct packed {
        logic [31:0] down_count;
        logic [31:0] reload_period;
        logic [31:0] prescale_divisor;
        logic [31:0] prescale_counter;
        logic zero_reached_flag;
        logic zero_irq_enable;
        logic free_run;
        logic soft_halt;
        logic halt_request_bit;
        cputmr_emu_t emu;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } cputmr_state_t;
endpackage

// >>> verif/cputmr_host.sv
// Host model: memory-bus master and debugger halt line
`timescale 1ns/1ps
module cputmr_host (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output cputmr_pkg::cputmr_bus_t bus_o,
    output logic halt_o
);
    import cputmr_pkg::*;
    initial begin
        bus_o = '0;
        halt_o = 1'b0;
    end
    // One strobe per access; idle data inverted so no stale value helps
    // Read or write access issued by host
    task automatic access(input logic w, input logic [2:0] a,
                          input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        bus_o.wr <= w;
        bus_o.rd <= ~w;
        bus_o.addr <= a;
        bus_o.wdata <= d;
        @(posedge clk_i);
        bus_o.wr <= 1'b0;
        bus_o.rd <= 1'b0;
        bus_o.wdata <= ~d;
        @(negedge clk_i);
        q = rdata_i;
    endtask
    task automatic set_halt(input logic h);
        @(posedge clk_i);
        halt_o <= h;
    endtask
endmodule

// >>> verif/cputmr_top_tb.sv
// Testbench: random and corner checks of the timer control flags
`timescale 1ns/1ps
module cputmr_top_tb;
    import cputmr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    cputmr_bus_t bus;
    logic halt;
    logic [15:0] rdata;
    logic irq;
    logic [15:0] q, junk, c1;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int irq_cnt = 0;
    int last_irq = 0;
    int per, div, t0, n;

    cputmr_top u_dut (.CLK_I(clk), .SYS_RST_I(rst), .BUS_I(bus),
        .BUS_RDATA_O(rdata), .DEBUG_HALT_I(halt), .ZERO_IRQ_O(irq));
    cputmr_host u_host (.clk_i(clk), .rdata_i(rdata), .bus_o(bus),
        .halt_o(halt));

    initial begin
        forever #50 clk = ~clk;
    end

    // Cycle count, interrupt monitor and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            last_irq <= cyc;
        end
        if (cyc == 20000) begin
            error_cnt++;
            $display("Error at %0t: timeout", $time);
            wrap_up();
        end
    end

    function automatic logic [15:0] gap(int p, int d);
        return 16'((p + 1) * (d + 1));
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        u_host.access(1'b1, a, d, junk);
    endtask

    task automatic rd(input logic [2:0] a);
        u_host.access(1'b0, a, 16'($urandom), q);
    endtask

    task automatic setup(input int p, input int d);
        wr(OFF_TCR, 16'h0010);
        wr(OFF_PRD_LO, 16'(p));
        wr(OFF_PRD_HI, 16'h0000);
        wr(OFF_DIV_LO, 16'(d));
        wr(OFF_DIV_HI, 16'h0000);
    endtask

    // Bounded wait for the next interrupt pulse
    task automatic wait_irq();
        int k;
        k = irq_cnt;
        for (int i = 0; i < 2000 && irq_cnt == k; i++) begin
            @(posedge clk);
        end
        @(negedge clk);
        check(16'(irq_cnt == k), 16'h0000);
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        t0 = $urandom(39);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_TCR);
        check(q, 16'h0000);
        // Stop bit is clear out of reset, so the count has moved
        rd(OFF_CNT_LO);
        check(16'(q == RST_COUNT[15:0]), 16'h0000);
        wr(3'h5, 16'($urandom));
        rd(3'h5);
        check(q, 16'h0000);
        for (int r = 0; r < 4; r++) begin
            per = (r == 0) ? 1 : 2 + $urandom % 20;
            div = (r == 0) ? 0 : $urandom % 4;
            setup(per, div);
            wr(OFF_TCR, 16'h4020);
            wait_irq();
            t0 = last_irq;
            wait_irq();
            check(16'(last_irq - t0), gap(per, div));
            rd(OFF_TCR);
            check(q, 16'hC000);
        end
        wr(OFF_TCR, 16'h0010);
        rd(OFF_TCR);
        check(q, 16'h8010);
        wr(OFF_TCR, 16'h8010);
        rd(OFF_TCR);
        check(q, 16'h0010);
        setup(5, 1);
        wr(OFF_TCR, 16'h0020);
        n = irq_cnt;
        repeat (200) @(posedge clk);
        check(16'(irq_cnt), 16'(n));
        rd(OFF_TCR);
        check(q, 16'h8000);
        setup(40, 0);
        wr(OFF_TCR, 16'h4C20);
        u_host.set_halt(1'b1);
        wait_irq();
        t0 = last_irq;
        wait_irq();
        check(16'(last_irq - t0), gap(40, 0));
        wr(OFF_TCR, 16'h4020);
        rd(OFF_CNT_LO);
        c1 = q;
        // Reload to 40, one more decrement, then frozen
        check(c1, 16'h0027);
        repeat (10) @(posedge clk);
        rd(OFF_CNT_LO);
        check(q, c1);
        u_host.set_halt(1'b0);
        // Freeze lifts one edge after release; give it time to count
        repeat (2) @(posedge clk);
        rd(OFF_CNT_LO);
        check(16'(q == c1), 16'h0000);
        wr(OFF_TCR, 16'h4420);
        u_host.set_halt(1'b1);
        wait_irq();
        n = irq_cnt;
        repeat (100) @(posedge clk);
        check(16'(irq_cnt), 16'(n));
        rd(OFF_CNT_LO);
        check(q, 16'h0000);
        u_host.set_halt(1'b0);
        wrap_up();
    end
endmodule
